// ==== pkg/psram_pkg.sv ====
// shared constants for the octal ddr psram link
// assumes a 50 mhz system clock on both ends
package psram_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ          = 50;
  localparam int SELF_INIT_US     = 150;
  localparam int SELF_INIT_CYCLES = (SELF_INIT_US * CLK_MHZ + 0);
  localparam int RESET_LOW_CYCLES = 4;
  localparam int MAX_SELECT_LOW   = 4000;
  localparam int GRST_CLOCKS      = 4;
  localparam int LC_BASE          = 3;
  localparam int HOST_LC          = 8;
  // ------------------------------------------------------------
  // bus layout
  // ------------------------------------------------------------
  localparam int ADDR_W    = 23;
  localparam int ROW_W     = 13;
  localparam int COL_W     = 10;
  localparam int MEM_BYTES = 8388608;
  localparam int FIFO_W    = 9;
  localparam int FIFO_D    = 16;
  // ------------------------------------------------------------
  // instructions
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_RD      = 8'h80;
  localparam logic [7:0] CMD_RD_LIN  = 8'ha0;
  localparam logic [7:0] CMD_WR      = 8'h00;
  localparam logic [7:0] CMD_WR_LIN  = 8'h20;
  localparam logic [7:0] CMD_MRW_A   = 8'h40;
  localparam logic [7:0] CMD_MRW_B   = 8'h60;
  localparam logic [7:0] CMD_GRST    = 8'hff;
  localparam int         LINEAR_BIT  = 5;
  // ------------------------------------------------------------
  // mode register (low byte) and wrap masks
  // ------------------------------------------------------------
  localparam logic [7:0] MR_DEFAULT  = 8'h52;
  localparam int         MR_LC_LSB   = 4;
  localparam logic [9:0] WRAP_128    = 10'h07f;
  localparam logic [9:0] WRAP_64     = 10'h03f;
  localparam logic [9:0] WRAP_32     = 10'h01f;
  localparam logic [9:0] WRAP_16     = 10'h00f;
  localparam logic [9:0] WRAP_PAGE   = 10'h3ff;
endpackage

// ==== pkg/psram_link_if.sv ====
// link wires between the octal ddr controller and the psram
// resolves shared pins from the output enables of both ends
`timescale 1ns/1ns
interface psram_link_if;
  logic       sel_n;
  logic       link_clk;
  logic       init_n_drv;
  logic       init_n_oe;
  logic       init_n;
  logic [7:0] host_adq;
  logic       host_adq_oe;
  logic [7:0] dev_adq;
  logic       dev_adq_oe;
  logic       host_sm;
  logic       host_sm_oe;
  logic       dev_sm;
  logic       dev_sm_oe;
  logic [7:0] adq;
  logic       strobe_mask;

  // weak pull-up keeps the init pin inactive when undriven
  assign init_n      = init_n_oe ? init_n_drv : 1'b1;
  assign adq         = dev_adq_oe ? dev_adq : (host_adq_oe ? host_adq : 8'h00);
  assign strobe_mask = dev_sm_oe ? dev_sm : (host_sm_oe ? host_sm : 1'b0);

  modport device (
    input  sel_n, link_clk, init_n, adq, strobe_mask,
    output dev_adq, dev_adq_oe, dev_sm, dev_sm_oe
  );
  modport host (
    output sel_n, link_clk, init_n_drv, init_n_oe,
    output host_adq, host_adq_oe, host_sm, host_sm_oe,
    input  adq, strobe_mask
  );
endinterface

// ==== src/psram_device.sv ====
// octal ddr psram device end: init, command capture, bursts
// assumes link pins synchronous to sys_clk_in; one link edge per cycle max
`timescale 1ns/1ns
// Behaviour
// - strobe out on reads, mask in on writes
// - select high forces standby, bus ignored
// - init pin active low, pulled up
// - 150 us self init before phase two
// - controller keeps select high, clock low early
// - ready after phase two; no sleep entries
// - init pin later resets all registers
// - global reset command completes phase two
// - global reset frame is four clocks
// - byte addressed, accesses start even
// - bursts wrap at configured boundary
// - writes carry at least two bytes
// - no minimum read, select low limited
// - two bytes per clock, both edges
// - linear bursts wrap at 1024 page
// - ten column and thirteen row bits
// - instruction, row, column on three clocks
module psram_device #(
  parameter int SELF_INIT_CYCLES = psram_pkg::SELF_INIT_CYCLES
) (
  // clock and reset
  input  wire logic     sys_clk_in,
  input  wire logic     rst_in,
  // link
  psram_link_if.device  link,
  // status
  output logic          ready_out,
  output logic [7:0]    mode_out
);
  import psram_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [8:0] {
    D_INIT1 = 9'h001,
    D_WAIT2 = 9'h002,
    D_GRST  = 9'h004,
    D_IDLE  = 9'h008,
    D_CMD   = 9'h010,
    D_LAT   = 9'h020,
    D_RD    = 9'h040,
    D_WR    = 9'h080,
    D_IGN   = 9'h100
  } dev_state_t;

  typedef struct packed {
    dev_state_t  st;
    logic [12:0] cnt;
    logic [2:0]  edge_n;
    logic [7:0]  inst;
    logic [12:0] row;
    logic [22:0] addr;
    logic [7:0]  mr;
    logic [3:0]  lat;
    logic        clk_prev;
    logic        ready;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        sm;
    logic        sm_oe;
  } dev_reg_t;

  dev_reg_t   r_reg;
  dev_reg_t   r_next;
  logic [7:0] mem_arr [0:MEM_BYTES-1];
  logic       mem_we;
  logic       rise;
  logic       fall;
  logic       edge_seen;
  logic [9:0] wrap_mask;
  logic [2:0] edge_idx;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [22:0] next_addr(input logic [22:0] a, input logic [9:0] m);
    logic [22:0] wm;
    wm = {13'h0000, m};
    return (a & ~wm) | ((a + 23'h000001) & wm);
  endfunction

  assign rise      = link.link_clk & ~r_reg.clk_prev;
  assign fall      = ~link.link_clk & r_reg.clk_prev;
  assign edge_seen = rise | fall;
  assign edge_idx  = r_reg.edge_n + 3'h1;

  always_comb begin
    case (r_reg.mr[1:0])
      2'b00:   wrap_mask = WRAP_128;
      2'b01:   wrap_mask = WRAP_64;
      2'b10:   wrap_mask = WRAP_32;
      default: wrap_mask = WRAP_16;
    endcase
    if (r_reg.inst[LINEAR_BIT]) begin
      wrap_mask = WRAP_PAGE;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_next          = r_reg;
    r_next.clk_prev = link.link_clk;
    mem_we          = 1'b0;
    case (r_reg.st)
      D_INIT1: begin
        r_next.cnt = r_reg.cnt + 13'h0001;
        if (r_reg.cnt == 13'(SELF_INIT_CYCLES - 1)) begin
          r_next.st = D_WAIT2;
        end
      end
      D_WAIT2: begin
        if (!link.sel_n && rise) begin
          r_next.edge_n = 3'h1;
          r_next.st     = (link.adq == CMD_GRST) ? D_GRST : D_IGN;
        end
      end
      D_GRST: begin
        if (rise && r_reg.edge_n != 3'h7) begin
          r_next.edge_n = r_reg.edge_n + 3'h1;
        end
        if (link.sel_n) begin
          r_next.st = D_WAIT2;
          if (r_reg.edge_n >= 3'(GRST_CLOCKS)) begin
            r_next.st    = D_IDLE;
            r_next.mr    = MR_DEFAULT;
            r_next.ready = 1'b1;
          end
        end
      end
      D_IDLE: begin
        if (!link.sel_n && rise) begin
          r_next.inst   = link.adq;
          r_next.edge_n = 3'h1;
          r_next.st     = D_CMD;
          r_next.sm     = 1'b0;
          r_next.sm_oe  = 1'b1;
        end
      end
      D_CMD: begin
        if (edge_seen) begin
          r_next.edge_n = edge_idx;
          case (edge_idx)
            3'h3:    r_next.row[12:8]  = link.adq[4:0];
            3'h4:    r_next.row[7:0]   = link.adq;
            3'h5:    r_next.addr[9:4]  = link.adq[7:2];
            3'h6: begin
              r_next.addr[3:0]   = link.adq[3:0];
              r_next.addr[22:10] = r_reg.row;
              r_next.lat         = 4'(LC_BASE) + r_reg.mr[MR_LC_LSB +: 4];
              case (r_reg.inst)
                CMD_RD, CMD_RD_LIN: r_next.st = D_LAT;
                CMD_WR, CMD_WR_LIN: begin
                  r_next.st    = D_LAT;
                  r_next.sm_oe = 1'b0;
                end
                CMD_MRW_A, CMD_MRW_B: begin
                  r_next.st    = D_WR;
                  r_next.sm_oe = 1'b0;
                end
                default: r_next.st = D_IGN;
              endcase
            end
            default: r_next.edge_n = edge_idx;
          endcase
        end
      end
      D_LAT: begin
        if (fall) begin
          r_next.lat = r_reg.lat - 4'h1;
          if (r_reg.lat == 4'h1) begin
            r_next.st = r_reg.inst[7] ? D_RD : D_WR;
          end
        end
      end
      D_RD: begin
        if (edge_seen) begin
          r_next.dq    = mem_arr[r_reg.addr];
          r_next.dq_oe = 1'b1;
          r_next.sm    = rise;
          r_next.addr  = next_addr(r_reg.addr, wrap_mask);
        end
      end
      D_WR: begin
        if (edge_seen) begin
          if (r_reg.inst == CMD_MRW_A || r_reg.inst == CMD_MRW_B) begin
            r_next.mr = link.adq;
            r_next.st = D_IGN;
          end else begin
            mem_we      = ~link.strobe_mask;
            r_next.addr = next_addr(r_reg.addr, wrap_mask);
          end
        end
      end
      D_IGN: begin
        r_next.dq_oe = 1'b0;
        r_next.sm_oe = 1'b0;
      end
      default: r_next.st = D_INIT1;
    endcase
    // select high ends any frame and leaves the bus alone
    if (link.sel_n && r_reg.ready) begin
      r_next.st     = D_IDLE;
      r_next.dq_oe  = 1'b0;
      r_next.sm_oe  = 1'b0;
      r_next.edge_n = 3'h0;
    end
    if (link.sel_n && r_reg.st == D_IGN && !r_reg.ready) begin
      r_next.st = D_WAIT2;
    end
    // init pin: phase two, or a full register reset later on
    if (!link.init_n && r_reg.st != D_INIT1) begin
      r_next.st     = D_IDLE;
      r_next.mr     = MR_DEFAULT;
      r_next.ready  = 1'b1;
      r_next.dq_oe  = 1'b0;
      r_next.sm_oe  = 1'b0;
      r_next.edge_n = 3'h0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      r_reg.st       <= D_INIT1;
      r_reg.cnt      <= 13'h0000;
      r_reg.edge_n   <= 3'h0;
      r_reg.inst     <= 8'h00;
      r_reg.row      <= 13'h0000;
      r_reg.addr     <= 23'h000000;
      r_reg.mr       <= MR_DEFAULT;
      r_reg.lat      <= 4'h0;
      r_reg.clk_prev <= 1'b0;
      r_reg.ready    <= 1'b0;
      r_reg.dq       <= 8'h00;
      r_reg.dq_oe    <= 1'b0;
      r_reg.sm       <= 1'b0;
      r_reg.sm_oe    <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // write data lands in the array, masked bytes are skipped
  always_ff @(posedge sys_clk_in) begin
    if (mem_we) begin
      mem_arr[r_reg.addr] <= link.adq;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign link.dev_adq    = r_reg.dq;
  assign link.dev_adq_oe = r_reg.dq_oe;
  assign link.dev_sm     = r_reg.sm;
  assign link.dev_sm_oe  = r_reg.sm_oe;
  assign ready_out       = r_reg.ready;
  assign mode_out        = r_reg.mr;

endmodule // psram_device

// ==== src/psram_host.sv ====
// octal ddr controller end with a write-data fifo
// assumes the device keeps its default latency code
`timescale 1ns/1ns
module psram_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_reg_t;
  fifo_reg_t        f_reg;
  fifo_reg_t        f_next;
  logic [WIDTH-1:0] buf_arr [0:DEPTH-1];
  logic             push;
  logic             pop;

  assign in_ready_out  = (f_reg.wp ^ f_reg.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid_out = f_reg.wp != f_reg.rp;
  assign out_data_out  = buf_arr[f_reg.rp[AW-1:0]];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    f_next    = f_reg;
    f_next.wp = f_reg.wp + (AW+1)'(push);
    f_next.rp = f_reg.rp + (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
    if (push) begin
      buf_arr[f_reg.wp[AW-1:0]] <= in_data_in;
    end
  end
endmodule // psram_fifo

module psram_host #(
  parameter int SELF_INIT_CYCLES = psram_pkg::SELF_INIT_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // link
  psram_link_if.host       link,
  // init choice: 1 uses the global reset command
  input  wire logic        init_by_cmd_in,
  output logic             ready_out,
  // requests
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic        req_read_in,
  input  wire logic        req_linear_in,
  input  wire logic [22:0] req_addr_in,
  input  wire logic [9:0]  req_pairs_in,
  output logic             done_out,
  // write data
  input  wire logic        wr_valid_in,
  output logic             wr_ready_out,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_mask_in,
  // read data
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out
);
  import psram_pkg::*;

  typedef enum logic [7:0] {
    H_PWR  = 8'h01,
    H_RST  = 8'h02,
    H_GRST = 8'h04,
    H_IDLE = 8'h08,
    H_CMD  = 8'h10,
    H_LAT  = 8'h20,
    H_DATA = 8'h40,
    H_END  = 8'h80
  } host_state_t;

  typedef struct packed {
    host_state_t st;
    logic [12:0] cnt;
    logic [11:0] left;
    logic [11:0] got;
    logic [12:0] sel_cnt;
    logic        rd;
    logic [7:0]  inst;
    logic [22:0] addr;
    logic        clk;
    logic        sel_n;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        sm;
    logic        sm_oe;
    logic        init_oe;
    logic        sm_prev;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        done;
    logic        ready;
  } host_reg_t;

  host_reg_t         h_reg;
  host_reg_t         h_next;
  logic              f_valid;
  logic              f_pop;
  logic [FIFO_W-1:0] f_data;
  logic [7:0]        ab;

  psram_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (wr_valid_in),
    .in_ready_out  (wr_ready_out),
    .in_data_in    ({wr_mask_in, wr_data_in}),
    .out_valid_out (f_valid),
    .out_ready_in  (f_pop),
    .out_data_out  (f_data)
  );

  // address byte sent on the next command edge
  always_comb begin
    case (h_reg.cnt[2:0])
      3'h2:    ab = {3'h0, h_reg.addr[22:18]};
      3'h3:    ab = h_reg.addr[17:10];
      3'h4:    ab = {h_reg.addr[9:4], 2'h0};
      3'h5:    ab = {4'h0, h_reg.addr[3:0]};
      default: ab = 8'h00;
    endcase
  end

  assign f_pop = (h_reg.st == H_DATA) & ~h_reg.rd & f_valid & (h_reg.left != 12'h000);

  always_comb begin
    h_next         = h_reg;
    h_next.rvalid  = 1'b0;
    h_next.done    = 1'b0;
    h_next.sm_prev = link.strobe_mask;
    h_next.sel_cnt = h_reg.sel_n ? 13'h0000 : h_reg.sel_cnt + 13'h0001;
    case (h_reg.st)
      H_PWR: begin
        h_next.cnt = h_reg.cnt + 13'h0001;
        if (h_reg.cnt == 13'(SELF_INIT_CYCLES - 1)) begin
          h_next.cnt     = 13'h0000;
          h_next.st      = init_by_cmd_in ? H_GRST : H_RST;
          h_next.init_oe = ~init_by_cmd_in;
          h_next.sel_n   = ~init_by_cmd_in;
        end
      end
      H_RST: begin
        h_next.cnt = h_reg.cnt + 13'h0001;
        if (h_reg.cnt == 13'(RESET_LOW_CYCLES - 1)) begin
          h_next.init_oe = 1'b0;
          h_next.st      = H_END;
        end
      end
      H_GRST: begin
        h_next.clk   = ~h_reg.clk;
        h_next.cnt   = h_reg.cnt + 13'h0001;
        h_next.dq_oe = 1'b1;
        h_next.dq    = CMD_GRST;
        if (h_reg.cnt == 13'(2 * GRST_CLOCKS - 1)) begin
          h_next.st = H_END;
        end
      end
      H_IDLE: begin
        if (req_valid_in) begin
          h_next.rd    = req_read_in;
          h_next.inst  = {req_read_in, 1'b0, req_linear_in, 5'h00};
          h_next.addr  = {req_addr_in[22:1], 1'b0};
          h_next.left  = {1'b0, (req_pairs_in == 10'h000) ? 10'h001 : req_pairs_in, 1'b0};
          h_next.got   = 12'h000;
          h_next.cnt   = 13'h0000;
          h_next.sel_n = 1'b0;
          h_next.st    = H_CMD;
        end
      end
      H_CMD: begin
        h_next.clk   = ~h_reg.clk;
        h_next.dq_oe = 1'b1;
        h_next.dq    = (h_reg.cnt == 13'h0000) ? h_reg.inst : ab;
        h_next.cnt   = h_reg.cnt + 13'h0001;
        if (h_reg.cnt == 13'h0005) begin
          h_next.cnt = 13'h0000;
          h_next.st  = H_LAT;
        end
      end
      H_LAT: begin
        h_next.clk   = ~h_reg.clk;
        h_next.dq    = 8'h00;
        h_next.dq_oe = ~h_reg.rd;
        h_next.cnt   = h_reg.cnt + 13'h0001;
        if (h_reg.cnt == 13'(2 * HOST_LC - 1)) begin
          h_next.st = H_DATA;
        end
      end
      H_DATA: begin
        if (h_reg.rd) begin
          if (h_reg.left != 12'h000) begin
            h_next.clk  = ~h_reg.clk;
            h_next.left = h_reg.left - 12'h001;
          end
          // the strobe trails the clock by one edge: close only once it is quiet
          if (link.strobe_mask != h_reg.sm_prev) begin
            h_next.rdata  = link.adq;
            h_next.rvalid = 1'b1;
            h_next.got    = h_reg.got + 12'h001;
          end else if (h_reg.left == 12'h000 && h_reg.got[0] == 1'b0 && h_reg.got != 12'h000) begin
            h_next.st = H_END;
          end
        end else if (f_pop) begin
          h_next.clk   = ~h_reg.clk;
          h_next.dq    = f_data[7:0];
          h_next.sm    = f_data[8];
          h_next.sm_oe = 1'b1;
          h_next.left  = h_reg.left - 12'h001;
        end else if (h_reg.left == 12'h000) begin
          h_next.st = H_END;
        end
        if (h_reg.sel_cnt >= 13'(MAX_SELECT_LOW) && !h_reg.clk) begin
          h_next.st = H_END;
        end
      end
      H_END: begin
        h_next.sel_n = 1'b1;
        h_next.clk   = 1'b0;
        h_next.dq_oe = 1'b0;
        h_next.sm_oe = 1'b0;
        h_next.done  = h_reg.ready;
        h_next.ready = 1'b1;
        h_next.st    = H_IDLE;
      end
      default: h_next.st = H_PWR;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      h_reg       <= '0;
      h_reg.st    <= H_PWR;
      h_reg.sel_n <= 1'b1;
    end else begin
      h_reg <= h_next;
    end
  end

  assign link.sel_n       = h_reg.sel_n;
  assign link.link_clk    = h_reg.clk;
  assign link.init_n_drv  = 1'b0;
  assign link.init_n_oe   = h_reg.init_oe;
  assign link.host_adq    = h_reg.dq;
  assign link.host_adq_oe = h_reg.dq_oe;
  assign link.host_sm     = h_reg.sm;
  assign link.host_sm_oe  = h_reg.sm_oe;
  assign ready_out        = h_reg.ready;
  assign req_ready_out    = h_reg.st == H_IDLE;
  assign done_out         = h_reg.done;
  assign rd_data_out      = h_reg.rdata;
  assign rd_valid_out     = h_reg.rvalid;

endmodule // psram_host

// ==== verification/psram_link_sva.sv ====
// checker on the link wires between the two ends
// assumes one system clock; wires arrive as plain inputs
`timescale 1ns/1ns
module psram_link_sva
  import psram_pkg::*;
(
  // clock and reset
  input logic       sys_clk_in,
  input logic       rst_in,
  // link wires
  input logic       sel_n,
  input logic       link_clk,
  input logic       init_n,
  input logic [7:0] adq,
  input logic       dev_adq_oe,
  input logic       host_adq_oe,
  input logic       dev_sm_oe,
  input logic       host_sm_oe
);
  logic        clk_q;
  logic        ff_q;
  logic [12:0] edg;
  logic [12:0] low_cnt;
  wire         tg = link_clk != clk_q;

  // ------------------------------------------------------------
  // link toggles and select-low time within a frame
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    clk_q <= link_clk;
    if (rst_in || sel_n) begin
      edg     <= 13'h0;
      low_cnt <= 13'h0;
    end else begin
      low_cnt <= low_cnt + 13'h1;
      if (tg) edg <= edg + 13'h1;
    end
    if (rst_in) ff_q <= 1'b0;
    else if (tg && !sel_n && edg == 13'h0) ff_q <= (adq == 8'hff);
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_standby_quiet: assert property (sel_n [*2] |-> !dev_adq_oe && !dev_sm_oe)
    else $error("device drives while deselected");
  a_one_owner: assert property (!(dev_adq_oe && host_adq_oe) && !(dev_sm_oe && host_sm_oe))
    else $error("two drivers on a shared pin");
  a_clk_idle_low: assert property (sel_n [*2] |-> !link_clk)
    else $error("link clock high outside a frame");
  a_init_pulse_len: assert property ($fell(init_n) |-> !init_n [*4])
    else $error("init pulse too short");
  a_first_rise: assert property ($fell(sel_n) |-> !link_clk ##1 link_clk)
    else $error("frame does not open on a rising edge");
  a_cmd_dev_quiet: assert property ($fell(sel_n) |-> !dev_adq_oe [*7])
    else $error("device drives during command bytes");
  a_row_hi_bits: assert property (tg && edg == 13'h2 && !ff_q |-> adq[7:5] == 3'h0)
    else $error("row high byte has stray bits");
  a_col_lo_even: assert property (tg && edg == 13'h5 && !ff_q |-> adq[7:4] == 4'h0 && !adq[0])
    else $error("column low byte odd or stray bits");
  a_grst_four_clk: assert property ($rose(sel_n) && ff_q |-> edg >= 13'h7)
    else $error("global reset frame too short");
  a_sel_low_bound: assert property (low_cnt <= 13'(MAX_SELECT_LOW))
    else $error("select held low too long");
endmodule // psram_link_sva

// ==== verification/octal_ddr_psram_init_burst_tb_top.sv ====
// bench joining host and device ends through the link interface
// assumes both ends shortened to a 20 cycle self init
`timescale 1ns/1ns
module octal_ddr_psram_init_burst_tb_top;
  import psram_pkg::*;
  logic        sys_clk = 0;
  logic        rst = 1;
  logic        by_cmd = 0;
  logic        rq_v = 0;
  logic        rq_rd = 0;
  logic        rq_lin = 0;
  logic [22:0] rq_a = 0;
  logic [9:0]  rq_p = 0;
  logic        wv = 0;
  logic        wm = 0;
  logic [7:0]  wd = 0;
  logic        h_rdy, d_rdy, rq_rdy, done, wr_rdy, rd_v;
  logic [7:0]  mode, rd_d;
  logic [7:0]  mem[int];
  logic [7:0]  q[$];
  int          fails = 0;
  int          total_checks = 0;

  psram_link_if lk();
  psram_device #(.SELF_INIT_CYCLES(20)) psram_device_i (.sys_clk_in(sys_clk), .rst_in(rst), .link(lk.device),
    .ready_out(d_rdy), .mode_out(mode));
  psram_host #(.SELF_INIT_CYCLES(20)) psram_host_i (.sys_clk_in(sys_clk), .rst_in(rst), .link(lk.host),
    .init_by_cmd_in(by_cmd), .ready_out(h_rdy), .req_valid_in(rq_v), .req_ready_out(rq_rdy),
    .req_read_in(rq_rd), .req_linear_in(rq_lin), .req_addr_in(rq_a), .req_pairs_in(rq_p), .done_out(done),
    .wr_valid_in(wv), .wr_ready_out(wr_rdy), .wr_data_in(wd), .wr_mask_in(wm), .rd_data_out(rd_d),
    .rd_valid_out(rd_v));
  psram_link_sva psram_link_sva_i (.sys_clk_in(sys_clk), .rst_in(rst), .sel_n(lk.sel_n), .link_clk(lk.link_clk),
    .init_n(lk.init_n), .adq(lk.adq), .dev_adq_oe(lk.dev_adq_oe), .host_adq_oe(lk.host_adq_oe),
    .dev_sm_oe(lk.dev_sm_oe), .host_sm_oe(lk.host_sm_oe));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // next byte address: 32 byte wrap by default, 1024 byte page when linear
  function automatic logic [22:0] nxt(input logic [22:0] a, input logic lin);
    logic [22:0] m;
    m = lin ? 23'h3ff : 23'h01f;
    return (a & ~m) | ((a + 23'h1) & m);
  endfunction

  task automatic req(input logic rd, input logic lin, input logic [22:0] a, input logic [9:0] p);
    int n;
    rq_v = 1;
    rq_rd = rd;
    rq_lin = lin;
    rq_a = a;
    rq_p = p;
    while (rq_rdy !== 1'b1) tick();
    tick();
    rq_v = 0;
    n = 0;
    do begin
      tick();
      n++;
    end while (done !== 1'b1 && n < 3000);
    chk({7'h0, done}, 8'h1);
  endtask

  // fill the fifo first; a full fifo of 16 must refuse more
  task automatic wr(input logic lin, input logic [22:0] addr, input logic [9:0] p, input logic [7:0] base,
                    input logic mk);
    logic [22:0] a;
    a = addr & ~23'h1;
    for (int i = 0; i < 2 * p; i++) begin
      wv = 1;
      wd = base + 8'(i);
      wm = mk & ~i[0];
      while (wr_rdy !== 1'b1) tick();
      tick();
      if (!wm) mem[a] = wd;
      a = nxt(a, lin);
    end
    wv = 0;
    if (p == 8) chk({7'h0, wr_rdy}, 8'h0);
    req(0, lin, addr, p);
  endtask

  task automatic rd(input logic lin, input logic [22:0] addr, input logic [9:0] p);
    logic [22:0] a;
    a = addr & ~23'h1;
    q.delete();
    req(1, lin, addr, p);
    chk(8'(q.size()), 8'(2 * p));
    foreach (q[i]) begin
      chk(q[i], mem[a]);
      a = nxt(a, lin);
    end
  endtask

  // ------------------------------------------------------------
  // clock, read capture, watchdog, tests
  // ------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;

  // read bytes are taken mid-cycle, where the registered pulse has settled
  always @(negedge sys_clk) begin
    if (rd_v === 1'b1) q.push_back(rd_d);
  end

  initial begin
    #200000;
    fails++;
    close_out();
  end

  initial begin
    for (int m = 0; m < 2; m++) begin
      by_cmd = m[0];
      rst = 1;
      mem.delete();
      tick();
      tick();
      rst = 0;
      for (int n = 0; n < 500 && !(h_rdy === 1'b1 && d_rdy === 1'b1); n++) tick();
      chk({6'h0, h_rdy, d_rdy}, 8'h3);
      chk(mode, MR_DEFAULT);
      wr(0, 23'h1d, 8, 8'h10, 0);
      wr(0, 23'h1c, 8, 8'h80, 1);
      rd(0, 23'h1c, 8);
      rd(1, 23'h0, 6);
      wr(1, 23'h7fe, 2, 8'h40, 0);
      rd(1, 23'h400, 1);
      rd(1, 23'h7fe, 2);
    end
    close_out();
  end
endmodule // octal_ddr_psram_init_burst_tb_top
